// file: core/rsd_pkg.sv
// constants shared by the region size decode and identification bank
package rsd_pkg;

   // ---------------------------------------------------------------
   // address space and register port
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W      = 40;            // device address width
   localparam int unsigned HIGH_W      = ADDR_W - 32;   // base bits kept in setup high
   localparam int unsigned BUS_AW      = 12;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned ALIGN_LSB   = 15;            // lowest base bit ever constrained

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_SETUP_LOW  = 12'h000;
   localparam logic [11:0] OFS_SETUP_HIGH = 12'h004;
   localparam logic [11:0] OFS_ATTR       = 12'h008;
   localparam logic [11:0] OFS_STATUS     = 12'h00c;
   localparam logic [11:0] OFS_IDENT_0    = 12'hfe0;
   localparam logic [11:0] OFS_IDENT_1    = 12'hfe4;
   localparam logic [11:0] OFS_IDENT_2    = 12'hfe8;
   localparam logic [11:0] OFS_IDENT_3    = 12'hfec;
   localparam int unsigned IDENT_IDX_LSB  = 2;

   // ---------------------------------------------------------------
   // attribute and status fields
   // ---------------------------------------------------------------
   localparam int unsigned ATTR_EN_BIT     = 0;
   localparam int unsigned ATTR_SIZE_LSB   = 1;
   localparam int unsigned ATTR_SIZE_MSB   = 6;
   localparam int unsigned ST_USABLE_BIT   = 0;
   localparam int unsigned ST_MISALIGN_BIT = 1;
   localparam int unsigned ST_ACTIVE_BIT   = 2;
   localparam int unsigned ST_LOG2_LSB     = 8;
   localparam int unsigned ST_LOG2_MSB     = 14;

   // ---------------------------------------------------------------
   // size code decode
   // ---------------------------------------------------------------
   localparam logic [5:0] SIZE_CODE_MIN   = 6'h0e;      // 32KB, below is reserved
   localparam logic [5:0] SIZE_CODE_MAX   = 6'(ADDR_W - 1);
   localparam logic [6:0] SIZE_LOG2_BIAS  = 7'h01;      // bytes = 2**(code + 1)

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [5:0] RST_SIZE_CODE = 6'h00;
   localparam logic       RST_EN        = 1'b0;

   // ---------------------------------------------------------------
   // identification fields (values arbitrary)
   // ---------------------------------------------------------------
   localparam logic [3:0]  ID_FIX_REV    = 4'h0;
   localparam logic [3:0]  ID_CUST_MOD   = 4'h0;
   localparam logic [3:0]  ID_REVISION   = 4'h2;
   localparam logic        ID_MAKER_USED = 1'b1;
   localparam logic [6:0]  ID_MAKER_CODE = 7'h2c;
   localparam logic [11:0] ID_COMP_TYPE  = 12'h5a6;

endpackage : rsd_pkg

// file: core/rsd_size_decode.sv
// region size code to byte count and alignment mask
`timescale 1ns/1ps
module rsd_size_decode (
   input  wire logic [5:0]                       size_code_i,
   output logic      [6:0]                       size_log2_o,
   output logic                                  usable_o,
   output logic      [rsd_pkg::ADDR_W-1:rsd_pkg::ALIGN_LSB] keep_mask_o
);
   import rsd_pkg::*;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   assign size_log2_o = {1'b0, size_code_i} + SIZE_LOG2_BIAS;
   // codes past the address width cannot be reached, so they are refused
   assign usable_o    = (size_code_i >= SIZE_CODE_MIN)
                      && (size_code_i <= SIZE_CODE_MAX);

   genvar b;
   generate
      for (b = ALIGN_LSB; b < ADDR_W; b = b + 1) begin : g_mask
         // base bit survives only at or above the region size
         assign keep_mask_o[b] = (7'(b) >= size_log2_o);
      end
   endgenerate
endmodule : rsd_size_decode

// file: core/rsd_ident_rom.sv
// constant identification bytes, split across four registers
`timescale 1ns/1ps
module rsd_ident_rom (
   input  wire logic [1:0] index_i,
   output logic      [7:0] ident_byte_o
);
   import rsd_pkg::*;

   // ---------------------------------------------------------------
   // byte table
   // ---------------------------------------------------------------
   always_comb begin
      case (index_i)
         2'h0:    ident_byte_o = ID_COMP_TYPE[7:0];
         2'h1:    ident_byte_o = {ID_MAKER_CODE[3:0], ID_COMP_TYPE[11:8]};
         2'h2:    ident_byte_o = {ID_REVISION, ID_MAKER_USED, ID_MAKER_CODE[6:4]};
         2'h3:    ident_byte_o = {ID_FIX_REV, ID_CUST_MOD};
         default: ident_byte_o = 8'h00;
      endcase
   end
endmodule : rsd_ident_rom

// file: core/rsd_region_bank.sv
// register bank: region base, size decode and identification registers
// What this block does
// - size codes decode to power-of-two byte counts
// - base held in setup registers, alignment applied
// - identification low byte meaningful, upper undefined
// - identification registers constant, writes ignored
// - four identification bytes form one field word
// - maker code split across second, third bytes
// - component type split across first, second bytes
// - third byte upper nibble holds revision
// - third byte bit three always one
// - six-bit size field, small codes reserved
// - address width caps usable size codes
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
module rsd_region_bank (
   input  wire logic                      sys_clk_i,
   input  wire logic                      reset_i,
   input  wire logic [rsd_pkg::BUS_AW-1:0] addr_i,
   input  wire logic [rsd_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   output logic      [rsd_pkg::DATA_W-1:0] rdata_o,
   output logic      [rsd_pkg::ADDR_W-1:0] region_base_o,
   output logic      [6:0]                 region_size_log2_o,
   output logic                           region_active_o,
   output logic                           region_misaligned_o
);
   import rsd_pkg::*;

   // ---------------------------------------------------------------
   // stored state
   // ---------------------------------------------------------------
   logic [ADDR_W-1:ALIGN_LSB] base;
   logic [ADDR_W-1:ALIGN_LSB] next_base;
   logic [5:0]                size_code;
   logic [5:0]                next_size_code;
   logic                      en;
   logic                      next_en;

   // ---------------------------------------------------------------
   // derived outputs, registered
   // ---------------------------------------------------------------
   logic [ADDR_W-1:0]         eff_base;
   logic [ADDR_W-1:0]         next_eff_base;
   logic [6:0]                size_log2_q;
   logic [6:0]                next_size_log2_q;
   logic                      active;
   logic                      next_active;
   logic                      misaligned;
   logic                      next_misaligned;
   logic [DATA_W-1:0]         rdata;
   logic [DATA_W-1:0]         next_rdata;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   logic [6:0]                dec_log2;
   logic                      dec_usable;
   logic [ADDR_W-1:ALIGN_LSB] keep_mask;
   logic [ADDR_W-1:ALIGN_LSB] kept_bits;
   logic [ADDR_W-1:ALIGN_LSB] stray_bits;
   logic [1:0]                ident_idx;
   logic [7:0]                ident_byte;
   logic                      ident_hit;
   logic [DATA_W-1:0]         status_word;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   logic                      hit_setup_low;
   logic                      hit_setup_high;
   logic                      hit_attr;
   logic                      hit_status;
   logic                      wr_setup_low;
   logic                      wr_setup_high;
   logic                      wr_attr;

   // ---------------------------------------------------------------
   // read words
   // ---------------------------------------------------------------
   logic [DATA_W-1:0]         setup_low_word;
   logic [DATA_W-1:0]         setup_high_word;
   logic [DATA_W-1:0]         attr_word;
   logic [DATA_W-1:0]         ident_word;
   logic [DATA_W-1:0]         sel_word;

   rsd_size_decode u_size_decode (
      .size_code_i (size_code),
      .size_log2_o (dec_log2),
      .usable_o    (dec_usable),
      .keep_mask_o (keep_mask)
   );

   rsd_ident_rom u_ident_rom (
      .index_i      (ident_idx),
      .ident_byte_o (ident_byte)
   );

   // ---------------------------------------------------------------
   // offset match
   // ---------------------------------------------------------------
   assign hit_setup_low  = (addr_i == OFS_SETUP_LOW);
   assign hit_setup_high = (addr_i == OFS_SETUP_HIGH);
   assign hit_attr       = (addr_i == OFS_ATTR);
   assign hit_status     = (addr_i == OFS_STATUS);
   assign ident_hit      = (addr_i == OFS_IDENT_0) || (addr_i == OFS_IDENT_1)
                        || (addr_i == OFS_IDENT_2) || (addr_i == OFS_IDENT_3);
   assign ident_idx      = addr_i[IDENT_IDX_LSB+1:IDENT_IDX_LSB];

   // read-only offsets get no strobe, so writes there are dropped
   assign wr_setup_low   = wr_i && hit_setup_low;
   assign wr_setup_high  = wr_i && hit_setup_high;
   assign wr_attr        = wr_i && hit_attr;

   // ---------------------------------------------------------------
   // base address store
   // ---------------------------------------------------------------
   always_comb begin
      next_base = base;
      // bits below the lowest constrained one are never stored
      if (wr_setup_low) begin
         next_base[DATA_W-1:ALIGN_LSB] = wdata_i[DATA_W-1:ALIGN_LSB];
      end
      if (wr_setup_high) begin
         next_base[ADDR_W-1:DATA_W] = wdata_i[HIGH_W-1:0];
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         base <= '0;
      end else begin
         base <= next_base;
      end
   end

   // ---------------------------------------------------------------
   // attribute store
   // ---------------------------------------------------------------
   always_comb begin
      next_size_code = size_code;
      next_en        = en;
      if (wr_attr) begin
         next_size_code = wdata_i[ATTR_SIZE_MSB:ATTR_SIZE_LSB];
         next_en        = wdata_i[ATTR_EN_BIT];
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         size_code <= RST_SIZE_CODE;
         en        <= RST_EN;
      end else begin
         size_code <= next_size_code;
         en        <= next_en;
      end
   end

   // ---------------------------------------------------------------
   // region decode
   // ---------------------------------------------------------------
   // low base bits inside the region are ignored, not trusted
   assign kept_bits  = base & keep_mask;
   assign stray_bits = base & ~keep_mask;

   // ---------------------------------------------------------------
   // effective base
   // ---------------------------------------------------------------
   always_comb begin
      next_eff_base = {kept_bits, {ALIGN_LSB{1'b0}}};
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         eff_base <= '0;
      end else begin
         eff_base <= next_eff_base;
      end
   end

   // ---------------------------------------------------------------
   // region size
   // ---------------------------------------------------------------
   always_comb begin
      next_size_log2_q = dec_log2;
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         size_log2_q <= '0;
      end else begin
         size_log2_q <= next_size_log2_q;
      end
   end

   // ---------------------------------------------------------------
   // active flag
   // ---------------------------------------------------------------
   always_comb begin
      next_active = en && dec_usable;
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         active <= 1'b0;
      end else begin
         active <= next_active;
      end
   end

   // ---------------------------------------------------------------
   // misalignment flag
   // ---------------------------------------------------------------
   always_comb begin
      // flag software that broke the size boundary
      next_misaligned = dec_usable && (|stray_bits);
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         misaligned <= 1'b0;
      end else begin
         misaligned <= next_misaligned;
      end
   end

   // ---------------------------------------------------------------
   // region outputs
   // ---------------------------------------------------------------
   assign region_base_o       = eff_base;
   assign region_size_log2_o  = size_log2_q;
   assign region_active_o     = active;
   assign region_misaligned_o = misaligned;

   // ---------------------------------------------------------------
   // read words
   // ---------------------------------------------------------------
   always_comb begin
      status_word                              = '0;
      status_word[ST_USABLE_BIT]               = dec_usable;
      status_word[ST_MISALIGN_BIT]             = misaligned;
      status_word[ST_ACTIVE_BIT]               = active;
      status_word[ST_LOG2_MSB:ST_LOG2_LSB]     = size_log2_q;
   end

   always_comb begin
      setup_low_word                     = '0;
      setup_low_word[DATA_W-1:ALIGN_LSB] = base[DATA_W-1:ALIGN_LSB];
   end

   always_comb begin
      setup_high_word             = '0;
      setup_high_word[HIGH_W-1:0] = base[ADDR_W-1:DATA_W];
   end

   always_comb begin
      attr_word                              = '0;
      attr_word[ATTR_SIZE_MSB:ATTR_SIZE_LSB] = size_code;
      attr_word[ATTR_EN_BIT]                 = en;
   end

   always_comb begin
      // upper bits undefined, driven zero
      ident_word                        = '0;
      ident_word[$bits(ident_byte)-1:0] = ident_byte;
   end

   // ---------------------------------------------------------------
   // read select
   // ---------------------------------------------------------------
   always_comb begin
      sel_word = '0;
      if (ident_hit) begin
         // pure lookup, no state touched
         sel_word = ident_word;
      end else if (hit_setup_low) begin
         sel_word = setup_low_word;
      end else if (hit_setup_high) begin
         sel_word = setup_high_word;
      end else if (hit_attr) begin
         sel_word = attr_word;
      end else if (hit_status) begin
         sel_word = status_word;
      end
   end

   always_comb begin
      // idle cycles and unmapped offsets both read zero
      next_rdata = '0;
      if (rd_i) begin
         next_rdata = sel_word;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign rdata_o = rdata;
endmodule : rsd_region_bank

// file: sim/rsd_region_bank_monitor.sv
// port checker for the region bank
`timescale 1ns/1ps
module rsd_region_bank_monitor (
   input  wire logic                       sys_clk_i,
   input  wire logic                       reset_i,
   input  wire logic [rsd_pkg::BUS_AW-1:0] addr_i,
   input  wire logic [rsd_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                       wr_i,
   input  wire logic                       rd_i,
   input  wire logic [rsd_pkg::DATA_W-1:0] rdata_o,
   input  wire logic [rsd_pkg::ADDR_W-1:0] region_base_o,
   input  wire logic [6:0]                 region_size_log2_o,
   input  wire logic                       region_active_o,
   input  wire logic                       region_misaligned_o
);
   import rsd_pkg::*;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   wire        attr_wr  = wr_i && addr_i == OFS_ATTR;
   wire        code_ok  = wdata_i[0] && wdata_i[6:1] >= SIZE_CODE_MIN
                          && wdata_i[6:1] <= SIZE_CODE_MAX;
   wire [39:0] low_mask = (40'h1 << region_size_log2_o) - 40'h1;
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data not zero outside a read");
   a_ident_zero_val: assert property (rd_i && addr_i == OFS_IDENT_0 |=>
      rdata_o == {24'h0, ID_COMP_TYPE[7:0]}) else $error("ident byte 0 wrong");
   a_ident_one_val: assert property (rd_i && addr_i == OFS_IDENT_1 |=>
      rdata_o == {24'h0, ID_MAKER_CODE[3:0], ID_COMP_TYPE[11:8]})
      else $error("ident byte 1 wrong");
   a_ident_two_val: assert property (rd_i && addr_i == OFS_IDENT_2 |=>
      rdata_o == {24'h0, ID_REVISION, 1'b1, ID_MAKER_CODE[6:4]})
      else $error("ident byte 2 wrong");
   a_size_log2_val: assert property (attr_wr |-> ##2
      region_size_log2_o == 7'($past(wdata_i[6:1], 2)) + 7'h01)
      else $error("size log2 wrong");
   a_active_usable: assert property (attr_wr |-> ##2
      region_active_o == $past(code_ok, 2)) else $error("active flag wrong");
   a_base_aligned: assert property (region_active_o |->
      (region_base_o & low_mask) == 40'h0) else $error("base not masked");
   a_misalign_range: assert property (region_misaligned_o |->
      region_size_log2_o >= 7'h10 && region_size_log2_o <= 7'h28)
      else $error("misaligned flag for unconstrained size");
endmodule : rsd_region_bank_monitor

// file: sim/rsd_region_bank_tb_top.sv
// self-checking bench for the region bank
`timescale 1ns/1ps
module rsd_region_bank_tb_top;
   import rsd_pkg::*;
   logic        sys_clk_i = 1'b0;
   logic        reset_i   = 1'b1;
   logic [11:0] addr_i    = 12'h000;
   logic [31:0] wdata_i   = 32'h0;
   logic        wr_i      = 1'b0;
   logic        rd_i      = 1'b0;
   logic [31:0] rdata_o;
   logic [39:0] region_base_o;
   logic [6:0]  region_size_log2_o;
   logic        region_active_o;
   logic        region_misaligned_o;
   logic [31:0] d;
   int          fails = 0;
   int          samples_checked = 0;
   always #12.5 sys_clk_i = ~sys_clk_i;
   rsd_region_bank i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .region_base_o(region_base_o), .region_size_log2_o(region_size_log2_o),
      .region_active_o(region_active_o), .region_misaligned_o(region_misaligned_o));
   // ---------------------------------------------------------------
   // bus tasks and compare
   // ---------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge sys_clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      @(negedge sys_clk_i);
      v = rdata_o;
   endtask : rd
   // region outputs lag the store by one edge
   task automatic settle;
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask : settle
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_ident;
      logic [31:0] e [4];
      e[0] = {24'h0, ID_COMP_TYPE[7:0]};
      e[1] = {24'h0, ID_MAKER_CODE[3:0], ID_COMP_TYPE[11:8]};
      e[2] = {24'h0, ID_REVISION, 1'b1, ID_MAKER_CODE[6:4]};
      e[3] = {24'h0, ID_FIX_REV, ID_CUST_MOD};
      for (int i = 0; i < 4; i++) begin
         rd(OFS_IDENT_0 + 12'(4 * i), d);
         chk(d, e[i]);
         wr(OFS_IDENT_0 + 12'(4 * i), 32'hffff_ffff);
         rd(OFS_IDENT_0 + 12'(4 * i), d);
         chk(d, e[i]);
      end
      rd(12'h100, d);
      chk(d, 40'h0);
   endtask : t_ident
   task automatic t_sizes;
      for (int c = 13; c < 64; c++) begin
         wr(OFS_ATTR, {25'h0, 6'(c), 1'b1});
         settle;
         chk(region_size_log2_o, 40'(c + 1));
         chk(region_active_o, 40'(c >= 14 && c <= 39));
      end
      wr(OFS_ATTR, 32'hffff_ff83);
      rd(OFS_ATTR, d);
      chk(d, 40'h3);
   endtask : t_sizes
   task automatic t_align;
      wr(OFS_ATTR, 32'h43);
      wr(OFS_SETUP_LOW, 32'hffff_ffff);
      wr(OFS_SETUP_HIGH, 32'hffff_ff05);
      settle;
      chk(region_base_o, 40'h04_0000_0000);
      chk(region_misaligned_o, 40'h1);
      rd(OFS_STATUS, d);
      chk(d, 40'h2207);
      rd(OFS_SETUP_LOW, d);
      chk(d, 40'hffff_8000);
      rd(OFS_SETUP_HIGH, d);
      chk(d, 40'h05);
      wr(OFS_SETUP_LOW, 32'h0);
      wr(OFS_SETUP_HIGH, 32'h04);
      settle;
      chk(region_misaligned_o, 40'h0);
      wr(OFS_ATTR, 32'h45);
      settle;
      chk(region_misaligned_o, 40'h1);
      chk(region_base_o, 40'h0);
   endtask : t_align
   task automatic t_reset;
      wr(OFS_ATTR, 32'h43);
      wr(OFS_SETUP_HIGH, 32'h04);
      @(posedge sys_clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      @(negedge sys_clk_i);
      chk(region_size_log2_o, 40'h0);
      chk(region_base_o, 40'h0);
      @(negedge sys_clk_i);
      chk(region_size_log2_o, 40'h1);
      chk(region_active_o, 40'h0);
      rd(OFS_SETUP_HIGH, d);
      chk(d, 40'h0);
      rd(OFS_IDENT_2, d);
      chk(d, {32'h0, ID_REVISION, 1'b1, ID_MAKER_CODE[6:4]});
   endtask : t_reset
   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      t_ident;
      t_sizes;
      t_align;
      t_reset;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      fails++;
      report_and_stop;
   end
endmodule : rsd_region_bank_tb_top
bind rsd_region_bank rsd_region_bank_monitor i_mon (.sys_clk_i(sys_clk_i),
   .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .region_base_o(region_base_o),
   .region_size_log2_o(region_size_log2_o), .region_active_o(region_active_o),
   .region_misaligned_o(region_misaligned_o));
